// ==== rtl/imsu_top.sv ====
// interrupt mask and status unit with axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite.
`include "imsu_cfg.svh"

module imsu_top
	import imsu_pkg::*;
#(
	parameter logic [19:0] MAX_CYC = 20'(`IMSU_MAX_CYC)
)
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        setDefault,
	input  wire imsu_evt_t   evt,
	input  wire logic [7:0]  gpTimeoutHigh,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq,
	output logic             gpStepTick,
	output logic [19:0]      gpTimeoutCycles
);

	localparam int STEP_GAP = `IMSU_STEP_CYC;

	// sticky update: an unmasked event wins over a clear in the same cycle
	function automatic logic [7:0] stickyNext(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] msk,
		input logic [7:0] clr
	);
		stickyNext = (cur & ~clr) | (set & ~msk);
	endfunction

	// register index decode from a byte address
	function automatic logic [5:0] regIdx(input logic [7:0] a);
		regIdx = a[7:2];
	endfunction

	// software-visible state
	logic [7:0]  gptoQ;      // timeout low byte
	logic [7:2]  mainMskQ;   // main mask, bits 1..0 unused
	logic [7:0]  timMskQ;    // timer/nfc mask
	logic [7:0]  errMskQ;    // error/wake mask
	logic [7:2]  mainQ;      // main flags 7..2
	logic [7:0]  timQ;       // timer/nfc detail flags
	logic [7:0]  errQ;       // error/wake detail flags
	logic [7:0]  mainView;   // main register as read

	// write channel holding state
	logic        awHeldQ;    // write address taken
	logic        wHeldQ;     // write data taken
	logic [5:0]  awIdxQ;     // held write index
	logic [7:0]  wByteQ;     // held write byte
	logic        wLaneQ;     // low lane strobe held
	logic        bvalidQ;    // write answer pending
	logic [1:0]  brespQ;     // write answer code

	// read channel state
	logic        rvalidQ;    // read answer pending
	logic [1:0]  rrespQ;     // read answer code
	logic [31:0] rdataQ;     // read data

	// interrupt, divider and timeout outputs
	logic        irqQ;
	logic [4:0]  stepCntQ;
	logic        stepTickQ;
	logic [19:0] toCycQ;

	// decoded strobes
	logic        arTake;     // read address accepted
	logic [5:0]  arIdx;      // read index
	logic        wrDo;       // write performed this cycle
	logic        rdMain;     // main register read
	logic        rdTim;      // timer detail read
	logic        rdErr;      // error detail read
	logic        wrHit;      // write index is mapped
	logic        rdHit;      // read index is mapped
	logic [7:0]  rdByte;     // selected read byte
	logic [7:2]  swClr;      // software clear of main flags

	// summaries point at the detail registers
	always_comb
	begin
		mainView = {mainQ, 2'h0};
		mainView[`IMSU_BIT_TIM] = |timQ;  // see R10
		mainView[`IMSU_BIT_ERR] = |errQ;  // see R11
	end

	// bus handshakes: one item per channel while idle
	assign s_axi_awready = !awHeldQ;
	assign s_axi_wready  = !wHeldQ;
	assign s_axi_arready = !rvalidQ;
	assign arTake        = s_axi_arvalid && s_axi_arready;
	assign arIdx         = regIdx(s_axi_araddr);
	// write only once both halves are held and no answer waits
	assign wrDo          = awHeldQ && wHeldQ && !bvalidQ;

	// read side effects happen when the address is taken
	assign rdMain = arTake && (arIdx == `IMSU_IDX_MAIN);
	assign rdTim  = arTake && (arIdx == `IMSU_IDX_TIM);
	assign rdErr  = arTake && (arIdx == `IMSU_IDX_ERR);

	// write-only clear register acts on main flags 7..2
	assign swClr = (wrDo && wLaneQ && awIdxQ == `IMSU_IDX_CLR)
		? wByteQ[7:2] : 6'h00;

	// mapped-address checks
	always_comb
	begin
		unique case (awIdxQ)
			`IMSU_IDX_GPTO, `IMSU_IDX_MMSK, `IMSU_IDX_TMSK,
			`IMSU_IDX_EMSK, `IMSU_IDX_MAIN, `IMSU_IDX_TIM,
			`IMSU_IDX_ERR, `IMSU_IDX_CLR: wrHit = 1'b1;
			default: wrHit = 1'b0;
		endcase
	end

	// read multiplexer; the clear register reads as zero
	always_comb
	begin
		rdHit  = 1'b1;
		rdByte = `IMSU_RST_BYTE;
		unique case (arIdx)
			`IMSU_IDX_GPTO: rdByte = gptoQ;
			`IMSU_IDX_MMSK: rdByte = {mainMskQ, 2'h0};
			`IMSU_IDX_TMSK: rdByte = timMskQ;
			`IMSU_IDX_EMSK: rdByte = errMskQ;
			`IMSU_IDX_MAIN: rdByte = mainView;
			`IMSU_IDX_TIM:  rdByte = timQ;   // see R16
			`IMSU_IDX_ERR:  rdByte = errQ;   // see R17
			`IMSU_IDX_CLR:  rdByte = `IMSU_RST_BYTE;
			default:        rdHit  = 1'b0;
		endcase
	end

	// write address capture
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			awHeldQ <= 1'b0;
			awIdxQ  <= 6'h00;
		end
		else if (s_axi_awvalid && !awHeldQ)
		begin
			awHeldQ <= 1'b1;
			awIdxQ  <= regIdx(s_axi_awaddr);
		end
		else if (wrDo)
			awHeldQ <= 1'b0;
	end

	// write data capture; only the low byte lane matters
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			wHeldQ <= 1'b0;
			wByteQ <= `IMSU_RST_BYTE;
			wLaneQ <= 1'b0;
		end
		else if (s_axi_wvalid && !wHeldQ)
		begin
			wHeldQ <= 1'b1;
			wByteQ <= s_axi_wdata[7:0];
			wLaneQ <= s_axi_wstrb[0];
		end
		else if (wrDo)
			wHeldQ <= 1'b0;
	end

	// write answer; unmapped addresses get slverr
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			bvalidQ <= 1'b0;
			brespQ  <= `IMSU_RESP_OKAY;
		end
		else if (wrDo)
		begin
			bvalidQ <= 1'b1;
			brespQ  <= wrHit ? `IMSU_RESP_OKAY : `IMSU_RESP_SLV;
		end
		else if (s_axi_bready)
			bvalidQ <= 1'b0;
	end

	assign s_axi_bvalid = bvalidQ;
	assign s_axi_bresp  = brespQ;

	// read answer, registered one cycle after the address
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			rvalidQ <= 1'b0;
			rrespQ  <= `IMSU_RESP_OKAY;
			rdataQ  <= 32'h0000_0000;
		end
		else if (arTake)
		begin
			rvalidQ <= 1'b1;
			rrespQ  <= rdHit ? `IMSU_RESP_OKAY : `IMSU_RESP_SLV;
			rdataQ  <= {24'h00_0000, rdByte};
		end
		else if (s_axi_rready)
			rvalidQ <= 1'b0;
	end

	assign s_axi_rvalid = rvalidQ;
	assign s_axi_rresp  = rrespQ;
	assign s_axi_rdata  = rdataQ;

	// timeout low byte; writes to read-only indexes are ignored
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || setDefault)
			gptoQ <= `IMSU_RST_BYTE;  // see R6
		else if (wrDo && wLaneQ && awIdxQ == `IMSU_IDX_GPTO)
			gptoQ <= wByteQ;  // see R1
	end

	// mask registers, all unmasked after reset or set-default
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || setDefault)
		begin
			mainMskQ <= 6'h00;  // see R6
			timMskQ  <= `IMSU_RST_BYTE;
			errMskQ  <= `IMSU_RST_BYTE;
		end
		else if (wrDo && wLaneQ)
		begin
			if (awIdxQ == `IMSU_IDX_MMSK)
				mainMskQ <= wByteQ[7:2];  // see R3
			if (awIdxQ == `IMSU_IDX_TMSK)
				timMskQ <= wByteQ;  // see R4
			if (awIdxQ == `IMSU_IDX_EMSK)
				errMskQ <= wByteQ;  // see R5
		end
	end

	// main flags: masked events never set; a read clears 7..2
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || setDefault)
			mainQ <= 6'h00;  // see R7
		else
			// see R8 see R12 see R13 see R14 see R15
			mainQ <= (mainQ & ~(rdMain ? 6'h3F : swClr))
				| (evt.mainEvt & ~mainMskQ);
	end

	// timer/nfc detail flags clear only on their own read
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || setDefault)
			timQ <= `IMSU_RST_BYTE;
		else
			timQ <= stickyNext(timQ, evt.timEvt, timMskQ,
				rdTim ? 8'hFF : 8'h00);  // see R9 see R4
	end

	// error/wake detail flags clear only on their own read
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n || setDefault)
			errQ <= `IMSU_RST_BYTE;
		else
			errQ <= stickyNext(errQ, evt.errEvt, errMskQ,
				rdErr ? 8'hFF : 8'h00);  // see R9 see R5
	end

	// interrupt level; a mask set later also drops the request
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			irqQ <= 1'b0;
		else
			irqQ <= |(mainQ & ~mainMskQ)  // see R18
				| |(timQ & ~timMskQ) | |(errQ & ~errMskQ);
	end

	assign irq = irqQ;

	// timeout step divider; one tick per STEP_GAP (15) clock cycles
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			stepCntQ  <= 5'h00;
			stepTickQ <= 1'b0;
		end
		else if (stepCntQ == 5'(STEP_GAP - 1))
		begin
			stepCntQ  <= 5'h00;
			stepTickQ <= 1'b1;  // see R1
		end
		else
		begin
			stepCntQ  <= stepCntQ + 5'h01;
			stepTickQ <= 1'b0;
		end
	end

	assign gpStepTick = stepTickQ;

	// full timeout in clock cycles, capped at the longest timeout
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			toCycQ <= 20'h0_0000;
		else if (20'({gpTimeoutHigh, gptoQ}) * 20'(STEP_GAP) > MAX_CYC)
			toCycQ <= MAX_CYC;  // see R2
		else
			toCycQ <= 20'({gpTimeoutHigh, gptoQ}) * 20'(STEP_GAP);
	end

	assign gpTimeoutCycles = toCycQ;

	// main read with no new event leaves bits 7..2 clear
	a_main_read_clear: assert property (@(posedge ref_clk)  // see R8
		disable iff (!reset_n)
		(rdMain && (evt.mainEvt & ~mainMskQ) == 6'h00) |=> mainQ == 6'h00)
		else $error("main flags not cleared by read");

	// main read keeps the timer/nfc summary
	a_summary_keep: assert property (@(posedge ref_clk)  // see R9
		disable iff (!reset_n)
		(rdMain && !rdTim && !setDefault && timQ != 8'h00)
		|=> mainView[`IMSU_BIT_TIM])
		else $error("summary bit cleared by main read");

	// unmasked timer event raises the summary bit
	a_tim_summary: assert property (@(posedge ref_clk)  // see R10
		disable iff (!reset_n)
		((evt.timEvt & ~timMskQ) != 8'h00 && !setDefault)
		|=> mainView[`IMSU_BIT_TIM])
		else $error("timer summary not set");

	// unmasked error event raises the summary bit
	a_err_summary: assert property (@(posedge ref_clk)  // see R11
		disable iff (!reset_n)
		((evt.errEvt & ~errMskQ) != 8'h00 && !setDefault)
		|=> mainView[`IMSU_BIT_ERR])
		else $error("error summary not set");

	// unmasked main event sets its flag next cycle
	a_main_set: assert property (@(posedge ref_clk)  // see R15
		disable iff (!reset_n)
		(!setDefault && (evt.mainEvt & ~mainMskQ) != 6'h00)
		|=> (mainQ & $past(evt.mainEvt & ~mainMskQ))
			== $past(evt.mainEvt & ~mainMskQ))
		else $error("main event lost");

	// fully masked events leave clear flags clear
	a_mask_block: assert property (@(posedge ref_clk)  // see R3
		disable iff (!reset_n)
		(mainQ == 6'h00 && (evt.mainEvt & ~mainMskQ) == 6'h00)
		|=> mainQ == 6'h00)
		else $error("masked event set a flag");

	// set-default restores masks, flags and timeout byte
	a_set_default: assert property (@(posedge ref_clk)  // see R6
		disable iff (!reset_n)
		setDefault |=> (mainMskQ == 6'h00 && timMskQ == 8'h00
			&& errMskQ == 8'h00 && gptoQ == 8'h00 && mainQ == 6'h00
			&& timQ == 8'h00 && errQ == 8'h00))
		else $error("set-default did not clear");

	// interrupt follows unmasked flags one cycle later
	a_irq_level: assert property (@(posedge ref_clk)  // see R18
		disable iff (!reset_n)
		##1 irq == $past(|(mainQ & ~mainMskQ) | |(timQ & ~timMskQ)
			| |(errQ & ~errMskQ)))
		else $error("irq does not track flags");

	// step ticks are exactly one step apart
	a_step_tick: assert property (@(posedge ref_clk)  // see R1
		disable iff (!reset_n)
		gpStepTick |-> ##STEP_GAP gpStepTick)
		else $error("timeout step spacing wrong");

	// timeout cycles never exceed the longest timeout
	a_timeout_cap: assert property (@(posedge ref_clk)  // see R2
		disable iff (!reset_n)
		##1 gpTimeoutCycles <= MAX_CYC)
		else $error("timeout exceeds maximum");

endmodule // imsu_top

// ==== rtl/imsu_cfg.svh ====
// constants for the interrupt mask and status unit
// Contract
// R1 - timeout low byte held; step 590 ns (code: 15 clocks of 40 ns, 600 ns)
// R2 - sixteen-bit timeout spans 590 ns to 38.7 ms (code: 600 ns steps, capped at 38.7 ms)
// R3 - main mask bits 7..2 suppress six sources
// R4 - eight timer/nfc mask bits suppress sources
// R5 - eight error/wake mask bits suppress sources
// R6 - masks and timeout reset by set-default
// R7 - main flags cleared by power-up, set-default
// R8 - main read clears main bits 7..2
// R9 - bits 1,0 clear on detail read only
// R10 - bit 1 set by any timer/nfc event
// R11 - bit 0 set by any error/wake event
// R12 - bit 7 set when oscillator stable
// R13 - bit 6 set when rx fifo nearly full
// R14 - bit 6 set when tx fifo nearly empty
// R15 - bits 5..2: rxs, rxe, txe, collision
// R16 - timer/nfc detail register at 18h
// R17 - error/wake detail register at 19h
// R18 - irq high while unmasked flag set
`ifndef IMSU_CFG_SVH
`define IMSU_CFG_SVH

// register indexes; byte address is four times the index
`define IMSU_IDX_GPTO  6'h13
`define IMSU_IDX_MMSK  6'h14
`define IMSU_IDX_TMSK  6'h15
`define IMSU_IDX_EMSK  6'h16
`define IMSU_IDX_MAIN  6'h17
`define IMSU_IDX_TIM   6'h18
`define IMSU_IDX_ERR   6'h19
`define IMSU_IDX_CLR   6'h20

// reset value of every byte register
`define IMSU_RST_BYTE  8'h00
// summary bit positions inside the main flags
`define IMSU_BIT_TIM   1
`define IMSU_BIT_ERR   0

// bus answers
`define IMSU_RESP_OKAY 2'h0
`define IMSU_RESP_SLV  2'h2

// timing: one timeout step and the longest timeout
`define IMSU_CLK_NS    40
`define IMSU_STEP_NS   590
`define IMSU_STEP_CYC  ((`IMSU_STEP_NS + `IMSU_CLK_NS - 1) / `IMSU_CLK_NS)
`define IMSU_MAX_NS    38700000
`define IMSU_MAX_CYC   (`IMSU_MAX_NS / `IMSU_CLK_NS)

`endif

// ==== rtl/imsu_pkg.sv ====
// types shared by the interrupt mask and status unit
package imsu_pkg;
	// event pulses from the sources, one cycle each
	typedef struct packed {
		logic [7:2] mainEvt;  // osc, wl, rxs, rxe, txe, col
		logic [7:0] timEvt;   // timer and nfc sources
		logic [7:0] errEvt;   // error and wake-up sources
	} imsu_evt_t;
endpackage

// ==== tb/imsu_host_model.sv ====
// host model: axi4-lite master running single register cycles
module imsu_host_model
(
	input  wire logic        ref_clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus; payload lines carry junk, never a stale value
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wstrb} = 20'hA5C3F;
		wdata = 32'h5A5A5A5A;
	end

	// one write; all four byte strobes set, returns the write answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		r = 2'h3;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle budget here: only the bench watchdog ends a wait
		forever
		begin
			@(posedge ref_clk);
			// each channel released at its own handshake, payload scrambled
			if (awvalid && awready)
			begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready)
			begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
			if (bvalid && bready)
			begin
				bready <= 1'b0;
				r = bresp;
				break;
			end
		end
	endtask

	// one read; data taken at the rready handshake edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		d = 32'hFFFFFFFF;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (arvalid && arready)
			begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready)
			begin
				rready <= 1'b0;
				d = rdata;
				r = rresp;
				break;
			end
		end
	endtask
endmodule // imsu_host_model

// ==== tb/test_irq_mask_status_unit.sv ====
// self-checking bench for the interrupt mask and status unit
`include "imsu_cfg.svh"

module test_irq_mask_status_unit
	import imsu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// byte addresses, four times the register index
	localparam logic [7:0] A_TO = {`IMSU_IDX_GPTO, 2'b00};
	localparam logic [7:0] A_MM = {`IMSU_IDX_MMSK, 2'b00};
	localparam logic [7:0] A_TM = {`IMSU_IDX_TMSK, 2'b00};
	localparam logic [7:0] A_EM = {`IMSU_IDX_EMSK, 2'b00};
	localparam logic [7:0] A_MN = {`IMSU_IDX_MAIN, 2'b00};
	localparam logic [7:0] A_TD = {`IMSU_IDX_TIM, 2'b00};
	localparam logic [7:0] A_ED = {`IMSU_IDX_ERR, 2'b00};
	localparam logic [7:0] A_CL = {`IMSU_IDX_CLR, 2'b00};

	// one row: address, data written, word read back, response
	typedef struct packed {
		logic [7:0]  a;
		logic [7:0]  w;
		logic [31:0] e;
		logic [1:0]  r;
	} imsu_row_t;

	logic        refClk = 1'b0;
	logic        resetN = 1'b0;
	logic        setDefault = 1'b0;
	imsu_evt_t   evt = '0;
	logic [7:0]  gpTimeoutHigh = 8'h00;
	logic [7:0]  awaddr, araddr, b;
	logic [31:0] wdata, rdata, rd32;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, gpStepTick;
	logic [19:0] gpTimeoutCycles;
	int          n, nFail, testsRun;

	// main-mask row: unused low bits read back as zero
	imsu_row_t rows [6] = '{
		'{A_TO, 8'hA5, 32'h000000A5, 2'h0},
		'{A_MM, 8'hFF, 32'h000000FC, 2'h0},
		'{A_TM, 8'h5A, 32'h0000005A, 2'h0},
		'{A_EM, 8'hC3, 32'h000000C3, 2'h0},
		'{A_MN, 8'hFF, 32'h00000000, 2'h0},
		'{8'h70, 8'h11, 32'h00000000, 2'h2}};
	logic [7:0] clrList [7] = '{A_TO, A_MM, A_TM, A_EM, A_MN, A_TD, A_ED};

	always #20 refClk = ~refClk;

	imsu_host_model host (.ref_clk(refClk), .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);

	// timeout cap lowered so the capped case is reachable
	imsu_top #(.MAX_CYC(20'd100)) DUT (.ref_clk(refClk), .reset_n(resetN),
		.setDefault(setDefault), .evt(evt), .gpTimeoutHigh(gpTimeoutHigh),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
		.gpStepTick(gpStepTick), .gpTimeoutCycles(gpTimeoutCycles));

	task automatic chkData(input string nm, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e)
		begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkBit(input string nm, input logic e, input logic g);
		testsRun++;
		if (g !== e)
		begin
			nFail++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// read a mapped register, expect a byte and an okay answer
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd32, rs);
		chkData("read data", {24'h000000, e}, rd32);
		chkData("read resp", 32'h0, 32'(rs));
	endtask

	// one-cycle event pulse, then two edges so irq has settled
	task automatic fire(input imsu_evt_t v);
		@(posedge refClk);
		evt <= v;
		@(posedge refClk);
		evt <= '0;
		repeat (2) @(posedge refClk);
	endtask

	task automatic conclude;
		if (nFail == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard, well beyond the few hundred cycles needed
	initial
	begin
		#(40 * 20000);
		nFail++;
		conclude();
	end

	initial
	begin
		repeat (12) @(posedge refClk);
		resetN <= 1'b1;
		// table: reset value, write, read back, bus answer
		foreach (rows[k])
		begin
			host.rd(rows[k].a, rd32, rs);
			chkData("reset value", 32'h0, rd32);
			host.wr(rows[k].a, rows[k].w, rs);
			chkData("write resp", 32'(rows[k].r), 32'(rs));
			host.rd(rows[k].a, rd32, rs);
			chkData("read back", rows[k].e, rd32);
			chkData("read resp", 32'(rows[k].r), 32'(rs));
		end
		// timeout length in clocks: capped, then 5 steps of 15
		chkData("timeout cap", 32'd100, 32'(gpTimeoutCycles));
		host.wr(A_TO, 8'h05, rs);
		repeat (2) @(posedge refClk);
		chkData("timeout len", 32'd75, 32'(gpTimeoutCycles));
		// upper byte joins the value: 261 steps, so capped again
		gpTimeoutHigh <= 8'h01;
		repeat (2) @(posedge refClk);
		chkData("timeout high", 32'd100, 32'(gpTimeoutCycles));
		gpTimeoutHigh <= 8'h00;
		n = 0;
		repeat (150)
		begin
			@(posedge refClk);
			n += (gpStepTick === 1'b1);
		end
		chkData("step ticks", 32'd10, 32'(n));
		// each mask bit alone left open in all three groups
		for (int i = 0; i < 8; i++)
		begin
			b = 8'h01 << i;
			host.wr(A_MM, ~b, rs);
			host.wr(A_TM, ~b, rs);
			host.wr(A_EM, ~b, rs);
			fire('{6'h3F, 8'hFF, 8'hFF});
			chkBit("irq raised", 1'b1, irq);
			rdChk(A_MN, {b[7:2], 2'b11});
			rdChk(A_MN, 8'h03);
			rdChk(A_TD, b);
			rdChk(A_MN, 8'h01);
			rdChk(A_ED, b);
			rdChk(A_MN, 8'h00);
			@(posedge refClk);
			chkBit("irq idle", 1'b0, irq);
		end
		// mask set after the flag drops irq but keeps the flag
		host.wr(A_MM, 8'h00, rs);
		fire('{6'h01, 8'h00, 8'h00});
		chkBit("irq col", 1'b1, irq);
		host.wr(A_MM, 8'h04, rs);
		repeat (2) @(posedge refClk);
		chkBit("irq masked", 1'b0, irq);
		rdChk(A_MN, 8'h04);
		// write-only clear register
		fire('{6'h3F, 8'h00, 8'h00});
		host.wr(A_CL, 8'hFC, rs);
		rdChk(A_MN, 8'h00);
		rdChk(A_CL, 8'h00);
		// set-default with flags, masks and timeout all loaded
		fire('{6'h3F, 8'hFF, 8'hFF});
		@(posedge refClk);
		setDefault <= 1'b1;
		@(posedge refClk);
		setDefault <= 1'b0;
		foreach (clrList[k])
			rdChk(clrList[k], 8'h00);
		chkBit("irq cleared", 1'b0, irq);
		chkData("timeout zero", 32'h0, 32'(gpTimeoutCycles));
		// mid-run reset with flags pending and the bus idle
		fire('{6'h3F, 8'hFF, 8'hFF});
		chkBit("irq before reset", 1'b1, irq);
		resetN <= 1'b0;
		repeat (2) @(posedge refClk);
		resetN <= 1'b1;
		@(posedge refClk);
		chkBit("irq after reset", 1'b0, irq);
		rdChk(A_MN, 8'h00);
		rdChk(A_TD, 8'h00);
		conclude();
	end
endmodule // test_irq_mask_status_unit
